/* pkg/boundary_scan_pkg.sv */
// Shared constants, types and register map of the boundary-scan test port
package boundary_scan_pkg;

  // --------------------------------------------------------------------------
  // Chain geometry
  // --------------------------------------------------------------------------
  localparam int unsigned CHAIN_LEN = 236;
  localparam int unsigned CHAIN_ENABLE_CELLS = 28;
  localparam int unsigned CHAIN_EXTERNAL_CELLS = 205;
  localparam int unsigned CHAIN_EXTERNAL_SIGNALS = 117;
  localparam int unsigned CHAIN_INTERNAL_CELLS = 3;
  localparam int unsigned CHAIN_CLEAR_CELLS = 3;
  localparam int unsigned IR_LEN = 8;
  localparam int unsigned ID_LEN = 32;

  // --------------------------------------------------------------------------
  // Identification fields (values arbitrary)
  // --------------------------------------------------------------------------
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PRODUCT = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PRODUCT, ID_MAKER, 1'b1};

  // --------------------------------------------------------------------------
  // Instruction codes
  // --------------------------------------------------------------------------
  localparam logic [7:0] INSTR_EXTEST = 8'h00;
  localparam logic [7:0] INSTR_SAMPLE = 8'h01;
  localparam logic [7:0] INSTR_IDCODE = 8'h03;
  localparam logic [7:0] INSTR_BYPASS = 8'hff;
  localparam logic [7:0] IR_CAPTURE_VALUE = 8'h01;
  localparam logic [7:0] IR_RESET_VALUE = INSTR_IDCODE;

  // --------------------------------------------------------------------------
  // APB register map
  // --------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IDCODE = 12'h008;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
  localparam int unsigned CONTROL_ENABLE_BIT = 0;
  localparam int unsigned STATUS_STATE_POS = 0;
  localparam int unsigned STATUS_INSTR_POS = 16;
  localparam int unsigned STATUS_EXTEST_POS = 24;

  // --------------------------------------------------------------------------
  // Controller states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } tap_state_e;

  typedef enum logic [2:0] {
    SEL_BYPASS   = 3'b001,
    SEL_BOUNDARY = 3'b010,
    SEL_IDENT    = 3'b100
  } dr_select_e;

  // Test pins entering the block
  typedef struct packed {
    logic test_clock_pin;
    logic test_mode_select;
    logic test_serial_in;
  } test_pins_s;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage

/* verilog/pin_sync.sv */
// Two-flop synchroniser for inputs from outside the pclk domain
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= '0;
      sync_out <= '0;
    end else begin
      stage <= async_in;
      sync_out <= stage;
    end
  end

endmodule

/* verilog/boundary_scan_tap.sv */
// Boundary-scan test access port with APB control and status
//
// Added by the designer: the register offsets and the APB register port.
module boundary_scan_tap (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire boundary_scan_pkg::apb_req_s apb_req,
  output boundary_scan_pkg::apb_rsp_s apb_rsp,
  // Test port pins
  input wire boundary_scan_pkg::test_pins_s test_pins,
  input wire logic test_reset_n,
  output logic test_serial_out,
  output logic test_serial_out_oe_n,
  // Pad side of the chain
  input wire logic [boundary_scan_pkg::CHAIN_LEN-1:0] pad_capture,
  output logic [boundary_scan_pkg::CHAIN_LEN-1:0] pad_update,
  output logic extest_active
);
  import boundary_scan_pkg::*;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic dr_select_e decode_instr(input logic [IR_LEN-1:0] code);
    case (code)
      INSTR_EXTEST: decode_instr = SEL_BOUNDARY;
      INSTR_SAMPLE: decode_instr = SEL_BOUNDARY;
      INSTR_IDCODE: decode_instr = SEL_IDENT;
      default: decode_instr = SEL_BYPASS;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] addr, input logic [31:0] ctrl,
                                            input logic [31:0] stat);
    case (addr)
      ADDR_CONTROL: read_word = ctrl;
      ADDR_STATUS: read_word = stat;
      ADDR_IDCODE: read_word = ID_VALUE;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = (addr == ADDR_CONTROL) || (addr == ADDR_STATUS) || (addr == ADDR_IDCODE);
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] pins_sync;
  logic [CHAIN_LEN-1:0] pad_sync;
  logic tck_now;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic tap_rst_n;
  logic tap_rst_raw_n;

  pin_sync #(.WIDTH(3)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({test_pins.test_clock_pin, test_pins.test_mode_select, test_pins.test_serial_in}),
    .sync_out(pins_sync)
  );

  pin_sync #(.WIDTH(CHAIN_LEN)) u_pad_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pad_capture),
    .sync_out(pad_sync)
  );

  assign tck_now = pins_sync[2];
  assign tms = pins_sync[1];
  assign tdi = pins_sync[0];
  // Test reset acts at once; only its release is retimed to pclk
  assign tap_rst_raw_n = presetn & test_reset_n;

  pin_sync #(.WIDTH(1)) u_rst_sync (
    .pclk(pclk),
    .presetn(tap_rst_raw_n),
    .async_in(1'b1),
    .sync_out(tap_rst_n)
  );

  // --------------------------------------------------------------------------
  // APB register file
  // --------------------------------------------------------------------------
  logic [31:0] control;
  logic [31:0] status_word;
  logic port_enable;
  logic apb_access;
  tap_state_e state;
  logic [IR_LEN-1:0] instr;

  assign port_enable = control[CONTROL_ENABLE_BIT];
  assign apb_access = apb_req.psel && apb_req.penable;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STATUS_STATE_POS +: 16] = state;
    status_word[STATUS_INSTR_POS +: IR_LEN] = instr;
    status_word[STATUS_EXTEST_POS] = extest_active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CONTROL_RESET;
    end else if (apb_access && apb_rsp.pready && apb_req.pwrite && (apb_req.paddr == ADDR_CONTROL)) begin
      control <= {31'h0000_0000, apb_req.pwdata[CONTROL_ENABLE_BIT]};
    end
  end

  // One wait state, then a one-cycle answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp <= '0;
    end else if (apb_access && !apb_rsp.pready) begin
      apb_rsp.pready <= 1'b1;
      apb_rsp.pslverr <= !addr_mapped(apb_req.paddr);
      apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : read_word(apb_req.paddr, control, status_word);
    end else begin
      apb_rsp <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // Test clock edge detection
  // --------------------------------------------------------------------------
  // Pin idles low, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= tck_now;
    end
  end

  // Edges seen only while the port is enabled by software
  assign tck_rise = port_enable && tck_now && !tck_prev;
  assign tck_fall = port_enable && !tck_now && tck_prev;

  // --------------------------------------------------------------------------
  // Controller state machine
  // --------------------------------------------------------------------------
  tap_state_e next_state;

  always_comb begin
    case (state)
      ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_CAPTURE_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Instruction register
  // --------------------------------------------------------------------------
  logic [IR_LEN-1:0] ir_shift;
  dr_select_e dr_sel;

  assign dr_sel = decode_instr(instr);

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift <= IR_CAPTURE_VALUE;
    end else if (tck_rise) begin
      case (state)
        ST_CAPTURE_IR: ir_shift <= IR_CAPTURE_VALUE;
        ST_SHIFT_IR: ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      instr <= IR_RESET_VALUE;
    end else if (tck_rise) begin
      // Entering the reset state reloads the default instruction
      if (next_state == ST_RESET) begin
        instr <= IR_RESET_VALUE;
      end else if (state == ST_UPDATE_IR) begin
        instr <= ir_shift;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bypass and identification registers
  // --------------------------------------------------------------------------
  logic bypass_cell;
  logic [ID_LEN-1:0] id_shift;

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_cell <= 1'b0;
    end else if (tck_rise && (dr_sel == SEL_BYPASS)) begin
      case (state)
        ST_CAPTURE_DR: bypass_cell <= 1'b0;
        ST_SHIFT_DR: bypass_cell <= tdi;
        default: bypass_cell <= bypass_cell;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_shift <= ID_VALUE;
    end else if (tck_rise && (dr_sel == SEL_IDENT)) begin
      case (state)
        ST_CAPTURE_DR: id_shift <= ID_VALUE;
        ST_SHIFT_DR: id_shift <= {tdi, id_shift[ID_LEN-1:1]};
        default: id_shift <= id_shift;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Boundary chain
  // --------------------------------------------------------------------------
  logic [CHAIN_LEN-1:0] chain_shift;

  // One serial path; each pad direction owns its own cell
  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      chain_shift <= '0;
    end else if (tck_rise) begin
      // Top CHAIN_CLEAR_CELLS cells cleared on the edge that enters the reset state
      if (next_state == ST_RESET) begin
        chain_shift[CHAIN_LEN-1 -: CHAIN_CLEAR_CELLS] <= '0;
      end else if (dr_sel == SEL_BOUNDARY) begin
        case (state)
          ST_CAPTURE_DR: chain_shift <= pad_sync;
          ST_SHIFT_DR: chain_shift <= {tdi, chain_shift[CHAIN_LEN-1:1]};
          default: chain_shift <= chain_shift;
        endcase
      end
    end
  end

  // Parallel outputs hold still while the chain shifts
  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      pad_update <= '0;
    end else if (tck_rise) begin
      if (next_state == ST_RESET) begin
        pad_update[CHAIN_LEN-1 -: CHAIN_CLEAR_CELLS] <= '0;
      end else if ((state == ST_UPDATE_DR) && (dr_sel == SEL_BOUNDARY)) begin
        pad_update <= chain_shift;
      end
    end
  end

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      extest_active <= 1'b0;
    end else begin
      extest_active <= (instr == INSTR_EXTEST);
    end
  end

  // --------------------------------------------------------------------------
  // Serial output, changed on the falling test clock edge
  // --------------------------------------------------------------------------
  logic next_serial_out;
  logic shifting;

  assign shifting = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);

  always_comb begin
    if (state == ST_SHIFT_IR) begin
      next_serial_out = ir_shift[0];
    end else begin
      case (dr_sel)
        SEL_BOUNDARY: next_serial_out = chain_shift[0];
        SEL_IDENT: next_serial_out = id_shift[0];
        default: next_serial_out = bypass_cell;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      test_serial_out <= 1'b0;
      test_serial_out_oe_n <= 1'b1;
    end else if (tck_fall) begin
      test_serial_out <= next_serial_out;
      test_serial_out_oe_n <= !shifting;
    end
  end

endmodule

/* tb/boundary_scan_tap_assertions.sv */
// Concurrent checks on the ports of the boundary-scan test port
module boundary_scan_tap_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire boundary_scan_pkg::apb_req_s apb_req,
  input wire boundary_scan_pkg::apb_rsp_s apb_rsp,
  // Test port
  input wire boundary_scan_pkg::test_pins_s test_pins,
  input wire logic test_reset_n,
  input wire logic test_serial_out,
  input wire logic test_serial_out_oe_n,
  // Pads
  input wire logic [boundary_scan_pkg::CHAIN_LEN-1:0] pad_capture,
  input wire logic [boundary_scan_pkg::CHAIN_LEN-1:0] pad_update,
  input wire logic extest_active
);
  import boundary_scan_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wait_state_a:
    assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready missing after access phase");
  ready_pulse_a:
    assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready longer than one cycle");
  ready_cause_a:
    assert property ($rose(apb_rsp.pready) |-> $past(apb_req.psel && apb_req.penable))
    else $error("pready without access phase");
  idle_data_a:
    assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("read data or error outside pready");
  test_reset_a:
    assert property (!test_reset_n |-> test_serial_out_oe_n && !extest_active && pad_update[235:233] == 3'h0)
    else $error("test reset did not clear outputs");
  out_on_fall_a:
    assert property (disable iff (!presetn || !test_reset_n)
      $changed(test_serial_out) |-> !$past(test_pins.test_clock_pin, 3))
    else $error("serial out changed after a rising test clock");
  outputs_frozen_a:
    assert property (disable iff (!presetn || !test_reset_n)
      $stable(test_pins.test_clock_pin) [*8] |=> $stable(pad_update) && $stable(extest_active)
      && $stable(test_serial_out_oe_n))
    else $error("outputs moved without test clock edges");
  pad_hold_a:
    assert property (disable iff (!presetn || !test_reset_n) $changed(pad_update) |-> test_serial_out_oe_n)
    else $error("pad outputs changed while shifting");
  instr_hold_a:
    assert property (disable iff (!presetn || !test_reset_n) $changed(extest_active) |-> test_serial_out_oe_n)
    else $error("instruction changed while shifting");
endmodule

bind boundary_scan_tap boundary_scan_tap_assertions i_checks (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .test_pins(test_pins), .test_reset_n(test_reset_n),
  .test_serial_out(test_serial_out), .test_serial_out_oe_n(test_serial_out_oe_n),
  .pad_capture(pad_capture), .pad_update(pad_update), .extest_active(extest_active));

/* tb/scan_tester.sv */
// Model of the external boundary-scan tester
module scan_tester (
  // Clock
  input wire logic pclk,
  // Test pins
  output boundary_scan_pkg::test_pins_s pins,
  output logic trst_n,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pins = '0;
    trst_n = 1'b0;
  end
  // One 80 ns test clock period; clock rests low between calls
  task automatic step(input logic tms, input logic tdi, output logic out);
    pins.test_mode_select <= tms;
    pins.test_serial_in <= tdi;
    repeat (5) @(posedge pclk);
    out = tdo;
    pins.test_clock_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    pins.test_clock_pin <= 1'b0;
  endtask
  task automatic pulse_reset();
    trst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    trst_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the boundary-scan test port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import boundary_scan_pkg::*;
  typedef struct {string nm; logic [239:0] v; logic [239:0] m;} note_s;
  note_s notes[$];
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  test_pins_s pins;
  logic trst_n, tdo, tdo_oe_n, extest;
  logic seen_valid = 1'b0;
  logic oe_seen;
  logic [CHAIN_LEN-1:0] pad_in, pad_out;
  logic [239:0] seen, got, din, cap;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 33;
  always #4 pclk = ~pclk;
  boundary_scan_tap i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .test_pins(pins), .test_reset_n(trst_n), .test_serial_out(tdo), .test_serial_out_oe_n(tdo_oe_n),
    .pad_capture(pad_in), .pad_update(pad_out), .extest_active(extest));
  scan_tester i_tester (.pclk(pclk), .pins(pins), .trst_n(trst_n), .tdo(tdo));
  task automatic tally_and_finish();
    if (notes.size() != 0) n_fail++;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic note(input string nm, input logic [239:0] v, input logic [239:0] m);
    notes.push_back('{nm, v, m});
  endtask
  task automatic judge(input logic [239:0] g);
    note_s n;
    cmp_count++;
    if (notes.size() == 0) note("stray result", '0, '1);
    n = notes.pop_front();
    if (((g ^ n.v) & n.m) !== '0) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n.nm, n.v & n.m, g & n.m);
    end
  endtask
  always @(posedge pclk) begin
    if (apb_rsp.pready === 1'b1) judge({207'h0, apb_rsp.pslverr, apb_rsp.prdata});
    else if (seen_valid) judge(seen);
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int t;
    note($sformatf("apb %h", a), {207'h0, e}, {207'h0, 1'b1, {32{!w}}});
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (apb_rsp.pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_fail++;
      tally_and_finish();
    end
    apb_req <= '0;
    @(posedge pclk);
  endtask
  task automatic show(input string nm, input logic [239:0] v, input logic [239:0] m, input logic [239:0] g);
    note(nm, v, m);
    seen <= g;
    seen_valid <= 1'b1;
    @(posedge pclk);
    seen_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic walk(input logic [7:0] tms, input int n);
    logic o;
    for (int i = 0; i < n; i++) i_tester.step(tms[i], 1'b0, o);
  endtask
  task automatic shift(input int lo, input int hi);
    oe_seen = 1'b0;
    for (int i = lo; i < hi; i++) begin
      i_tester.step(i == hi - 1, din[i], got[i]);
      oe_seen = oe_seen | tdo_oe_n;
    end
    show("drive enable", 0, 1, {239'h0, oe_seen});
  endtask
  task automatic scan(input logic ir, input int n);
    got = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    shift(0, n);
    walk(8'h01, 2);
  endtask
  task automatic rnd();
    for (int k = 0; k < 8; k++) din[k*30+:30] = 30'($random(seed));
  endtask
  initial begin
    logic [7:0] code;
    pad_in = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    i_tester.pulse_reset();
    apb(0, ADDR_CONTROL, 0, {1'b0, CONTROL_RESET});
    apb(0, ADDR_STATUS, 0, {9'h0, IR_RESET_VALUE, ST_RESET});
    apb(1, ADDR_IDCODE, 32'h0, 33'h0);
    apb(0, ADDR_IDCODE, 0, {1'b0, ID_VALUE});
    apb(1, 12'h00c, 32'hffff_ffff, {1'b1, 32'h0});
    walk(8'h00, 1);
    rnd();
    scan(0, 32);
    show("ident", ID_VALUE, 32'hffff_ffff, got);
    din = INSTR_SAMPLE;
    scan(1, 8);
    show("ir capture", IR_CAPTURE_VALUE, 8'hff, got);
    apb(0, ADDR_STATUS, 0, {9'h0, INSTR_SAMPLE, ST_IDLE});
    rnd();
    cap = din;
    pad_in <= din[235:0];
    rnd();
    walk(8'h01, 3);
    shift(0, 100);
    walk(8'h04, 4);
    shift(100, 236);
    walk(8'h01, 2);
    show("chain out", cap, {4'h0, {236{1'b1}}}, got);
    show("pads", din, {4'h0, {236{1'b1}}}, {4'h0, pad_out});
    din = INSTR_EXTEST;
    scan(1, 8);
    apb(0, ADDR_STATUS, 0, {8'h01, INSTR_EXTEST, ST_IDLE});
    pad_in <= '1;
    walk(8'h01, 3);
    walk(8'h1f, 5);
    apb(0, ADDR_STATUS, 0, {9'h0, IR_RESET_VALUE, ST_RESET});
    show("cleared pads", 0, {7'h7, 233'h0}, {4'h0, pad_out});
    walk(8'h00, 1);
    code = 8'($random(seed)) & 8'h7f | 8'h04;
    for (int k = 0; k < 2; k++) begin
      din = k ? INSTR_BYPASS : code;
      scan(1, 8);
      rnd();
      scan(0, 16);
      show("bypass", {din[14:0], 1'b0}, 16'hffff, got);
    end
    apb(1, ADDR_CONTROL, 0, 33'h0);
    walk(8'h1f, 5);
    apb(0, ADDR_STATUS, 0, {9'h0, INSTR_BYPASS, ST_IDLE});
    apb(1, ADDR_CONTROL, 1, 33'h0);
    i_tester.pulse_reset();
    apb(0, ADDR_STATUS, 0, {9'h0, IR_RESET_VALUE, ST_RESET});
    tally_and_finish();
  end
endmodule
